// [tmrc_pkg.sv]
// constants shared by the dual timer/counter core
package tmrc_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_CTRL  = 8'h88;
   localparam logic [7:0] IDX_MODE  = 8'h89;
   localparam logic [7:0] IDX_T0L   = 8'h8A;
   localparam logic [7:0] IDX_T1L   = 8'h8B;
   localparam logic [7:0] IDX_T0H   = 8'h8C;
   localparam logic [7:0] IDX_T1H   = 8'h8D;
   localparam logic [7:0] IDX_CKSEL = 8'h8E;
   // control register bits
   localparam int CTRL_OVF1 = 7;
   localparam int CTRL_RUN1 = 6;
   localparam int CTRL_OVF0 = 5;
   localparam int CTRL_RUN0 = 4;
   // per-timer nibble of the mode register (timer 1 in the upper nibble)
   localparam int MODE_T1_LSB   = 4;
   localparam int MODE_GATE     = 3;
   localparam int MODE_CNT_SEL  = 2;
   localparam int MODE_SEL_HIGH = 1;
   localparam int MODE_SEL_LOW  = 0;
   // clock divider select bits
   localparam int CK_FAST1 = 4;
   localparam int CK_FAST0 = 3;
   // reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   // oscillator divide ratios
   localparam int DIV_FAST = 4;
   localparam int DIV_SLOW = 12;

   typedef enum logic [1:0] {
      MODE_PRESC13,
      MODE_FULL16,
      MODE_RELOAD8,
      MODE_SPLIT
   } tmrc_mode_t;
endpackage

// [tmrc_evt_if.sv]
// count-clock and pin events passed from the helper modules to the core
`timescale 1ns/1ps
`default_nettype none
interface tmrc_evt_if;
   logic       div4_en;
   logic       div12_en;
   logic [1:0] cnt_fall;
   logic [1:0] gate_hi;
   modport div_src (output div4_en, output div12_en);
   modport pin_src (output cnt_fall, output gate_hi);
   modport sink    (input div4_en, input div12_en, input cnt_fall, input gate_hi);
endinterface
`default_nettype wire

// [tmrc_prescale.sv]
// oscillator divider giving divide-by-4 and divide-by-12 enable pulses
`timescale 1ns/1ps
`default_nettype none
module tmrc_prescale (
   // clock and reset
   input  wire logic clk,
   input  wire logic resetn,
   // enables out
   tmrc_evt_if.div_src evt
);
   logic [3:0] div_cnt_ff;

   // one counter serves both ratios so the two rates stay phase locked
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         div_cnt_ff <= 4'h0;
      end else if (div_cnt_ff == 4'(tmrc_pkg::DIV_SLOW - 1)) begin
         div_cnt_ff <= 4'h0;
      end else begin
         div_cnt_ff <= div_cnt_ff + 4'h1;
      end
   end

   assign evt.div4_en  = (div_cnt_ff[1:0] == 2'(tmrc_pkg::DIV_FAST - 1));
   assign evt.div12_en = (div_cnt_ff == 4'(tmrc_pkg::DIV_SLOW - 1));

   a_fast_period : assert property (@(posedge clk) disable iff (!resetn)
      evt.div4_en |-> ##1 !evt.div4_en ##1 !evt.div4_en ##1 !evt.div4_en ##1 evt.div4_en)
      else $error("divide-by-4 enable period wrong");
   a_slow_period : assert property (@(posedge clk) disable iff (!resetn)
      evt.div12_en |-> ##1 !evt.div12_en [*8] ##1 !evt.div12_en [*3] ##1 evt.div12_en)
      else $error("divide-by-12 enable period wrong");
endmodule
`default_nettype wire

// [tmrc_pin_sync.sv]
// pin synchronisers and falling-edge detect for the count inputs
`timescale 1ns/1ps
`default_nettype none
module tmrc_pin_sync (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       resetn,
   // asynchronous pins
   input  wire logic [1:0] count_pin,
   input  wire logic [1:0] gate_input_pin,
   // events out
   tmrc_evt_if.pin_src     evt
);
   logic [1:0] cnt_meta_ff;
   logic [1:0] cnt_sync_ff;
   logic [1:0] cnt_last_ff;
   logic [1:0] gate_meta_ff;
   logic [1:0] gate_sync_ff;

   genvar i;
   generate
      for (i = 0; i < 2; i++) begin : g_pin
         always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
               cnt_meta_ff[i]  <= 1'b1;
               cnt_sync_ff[i]  <= 1'b1;
               cnt_last_ff[i]  <= 1'b1;
               gate_meta_ff[i] <= 1'b0;
               gate_sync_ff[i] <= 1'b0;
            end else begin
               cnt_meta_ff[i]  <= count_pin[i];
               cnt_sync_ff[i]  <= cnt_meta_ff[i];
               cnt_last_ff[i]  <= cnt_sync_ff[i];
               gate_meta_ff[i] <= gate_input_pin[i];
               gate_sync_ff[i] <= gate_meta_ff[i];
            end
         end
         assign evt.cnt_fall[i] = cnt_last_ff[i] & ~cnt_sync_ff[i];
         assign evt.gate_hi[i]  = gate_sync_ff[i];
         a_fall_single : assert property (@(posedge clk) disable iff (!resetn)
            evt.cnt_fall[i] |=> !evt.cnt_fall[i])
            else $error("count edge reported twice");
      end
   endgenerate
endmodule
`default_nettype wire

// [tmrc_core.sv]
// dual timer/counter core with apb register access
// Operation
// - gate set: count needs gate pin high
// - gate clear: run bit alone enables counting
// - counter-select clear: count divided internal clock
// - counter-select set: count falling count-pin edges
// - mode 0: 8-bit counter, 5-bit prescaler
// - mode 1: high and low bytes, 16 bits
// - mode 2: low byte reloads from high byte
// - mode 3: timer 0 split, high byte uses timer 1 run
// - timer 1 in mode 3 holds its count
// - timer 0 count bytes readable and writable
// - timer 1 count bytes readable and writable
// - timer 0 clock: divide by 4 or 12
// - timer 1 clock: divide by 4 or 12
// - overflow sets flag; service entry or software clears
// - run bit switches timer on and off
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module tmrc_core #(
   parameter int ADDR_W = 10
) (
   // clock and reset
   input  wire logic              clk,
   input  wire logic              resetn,
   // apb slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   // pins
   input  wire logic [1:0]        count_pin,
   input  wire logic [1:0]        gate_input_pin,
   // interrupt controller side
   input  wire logic [1:0]        isr_ack,
   output logic      [1:0]        overflow_flag
);
   tmrc_evt_if evt ();

   tmrc_prescale u_prescale (
      .clk    (clk),
      .resetn (resetn),
      .evt    (evt)
   );

   tmrc_pin_sync u_pin_sync (
      .clk            (clk),
      .resetn         (resetn),
      .count_pin      (count_pin),
      .gate_input_pin (gate_input_pin),
      .evt            (evt)
   );

   logic [7:0]          timer0_count_low_ff;
   logic [7:0]          timer0_count_high_ff;
   logic [7:0]          timer1_count_low_ff;
   logic [7:0]          timer1_count_high_ff;
   logic [7:0]          timer_mode_config_ff;
   logic [1:0]          clock_divider_select_ff;
   logic [1:0]          run_control_bit_ff;
   logic [1:0]          ovf_flag_ff;
   logic [31:0]         prdata_ff;
   logic [7:0]          reg_idx;
   logic                idx_hit;
   logic                wr_en;
   logic [7:0]          wbyte;
   logic [3:0]          cfg0;
   logic [3:0]          cfg1;
   tmrc_pkg::tmrc_mode_t mode0;
   tmrc_pkg::tmrc_mode_t mode1;
   logic                split0;
   logic                t0_int;
   logic                t1_int;
   logic                t0_adv;
   logic                t1_adv;
   logic                th0_adv;
   logic [16:0]         nxt_t0;
   logic [16:0]         nxt_t1;
   logic [8:0]          nxt_th0;
   logic [1:0]          ovf_set;
   logic [7:0]          ctrl_rd;

   // advance one count step; result is {overflow, high, low}
   function automatic logic [16:0] count_step(input tmrc_pkg::tmrc_mode_t md,
                                              input logic [7:0] hi,
                                              input logic [7:0] lo);
      logic [16:0] res;
      logic [13:0] s13;
      logic [8:0]  s8;
      res = {1'b0, hi, lo};
      s13 = 14'h0;
      s8  = 9'h0;
      unique case (md)
         tmrc_pkg::MODE_PRESC13: begin
            // upper three low-byte bits are left alone
            s13 = {1'b0, hi, lo[4:0]} + 14'h1;
            res = {s13[13], s13[12:5], lo[7:5], s13[4:0]};
         end
         tmrc_pkg::MODE_FULL16: begin
            res = {1'b0, hi, lo} + 17'h1;
         end
         tmrc_pkg::MODE_RELOAD8: begin
            s8  = {1'b0, lo} + 9'h1;
            res = s8[8] ? {1'b1, hi, hi} : {1'b0, hi, s8[7:0]};
         end
         tmrc_pkg::MODE_SPLIT: begin
            s8  = {1'b0, lo} + 9'h1;
            res = {s8[8], hi, s8[7:0]};
         end
      endcase
      return res;
   endfunction

   // register decode
   assign reg_idx = paddr[9:2];
   // shift instead of a part-select so the default ten-bit bus has no empty range
   assign idx_hit = (paddr[1:0] == 2'h0) && ((paddr >> 10) == '0) &&
                    (reg_idx >= tmrc_pkg::IDX_CTRL) && (reg_idx <= tmrc_pkg::IDX_CKSEL);
   assign wr_en   = psel & penable & pwrite & idx_hit;
   assign wbyte   = pwdata[7:0];
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~idx_hit;
   assign prdata  = prdata_ff;

   // mode fields and clock sources
   assign cfg0   = timer_mode_config_ff[3:0];
   assign cfg1   = timer_mode_config_ff[tmrc_pkg::MODE_T1_LSB +: 4];
   assign mode0  = tmrc_pkg::tmrc_mode_t'(cfg0[tmrc_pkg::MODE_SEL_HIGH:tmrc_pkg::MODE_SEL_LOW]);
   assign mode1  = tmrc_pkg::tmrc_mode_t'(cfg1[tmrc_pkg::MODE_SEL_HIGH:tmrc_pkg::MODE_SEL_LOW]);
   assign split0 = (mode0 == tmrc_pkg::MODE_SPLIT);
   assign t0_int = clock_divider_select_ff[0] ? evt.div4_en : evt.div12_en;
   assign t1_int = clock_divider_select_ff[1] ? evt.div4_en : evt.div12_en;

   // enable: run bit, optionally gated by the pin; source: internal or pin edge
   assign t0_adv = run_control_bit_ff[0]
                 & (~cfg0[tmrc_pkg::MODE_GATE] | evt.gate_hi[0])
                 & (cfg0[tmrc_pkg::MODE_CNT_SEL] ? evt.cnt_fall[0] : t0_int);
   assign t1_adv = run_control_bit_ff[1]
                 & (~cfg1[tmrc_pkg::MODE_GATE] | evt.gate_hi[1])
                 & (cfg1[tmrc_pkg::MODE_CNT_SEL] ? evt.cnt_fall[1] : t1_int)
                 & (mode1 != tmrc_pkg::MODE_SPLIT);
   // split high byte is a pure timer switched by the second run bit
   assign th0_adv = split0 & run_control_bit_ff[1] & t0_int;

   assign nxt_t0  = count_step(mode0, timer0_count_high_ff, timer0_count_low_ff);
   assign nxt_t1  = count_step(mode1, timer1_count_high_ff, timer1_count_low_ff);
   assign nxt_th0 = {1'b0, timer0_count_high_ff} + 9'h1;

   // in split mode the high byte borrows the second timer's flag
   assign ovf_set[0] = t0_adv & nxt_t0[16];
   assign ovf_set[1] = split0 ? (th0_adv & nxt_th0[8]) : (t1_adv & nxt_t1[16]);

   // timer 0 count; a software write beats a same-cycle count step
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         timer0_count_low_ff  <= tmrc_pkg::RST_BYTE;
         timer0_count_high_ff <= tmrc_pkg::RST_BYTE;
      end else begin
         if (wr_en && reg_idx == tmrc_pkg::IDX_T0L) begin
            timer0_count_low_ff <= wbyte;
         end else if (t0_adv) begin
            timer0_count_low_ff <= nxt_t0[7:0];
         end
         if (wr_en && reg_idx == tmrc_pkg::IDX_T0H) begin
            timer0_count_high_ff <= wbyte;
         end else if (th0_adv) begin
            timer0_count_high_ff <= nxt_th0[7:0];
         end else if (t0_adv && !split0) begin
            timer0_count_high_ff <= nxt_t0[15:8];
         end
      end
   end

   // timer 1 count
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         timer1_count_low_ff  <= tmrc_pkg::RST_BYTE;
         timer1_count_high_ff <= tmrc_pkg::RST_BYTE;
      end else begin
         if (wr_en && reg_idx == tmrc_pkg::IDX_T1L) begin
            timer1_count_low_ff <= wbyte;
         end else if (t1_adv) begin
            timer1_count_low_ff <= nxt_t1[7:0];
         end
         if (wr_en && reg_idx == tmrc_pkg::IDX_T1H) begin
            timer1_count_high_ff <= wbyte;
         end else if (t1_adv) begin
            timer1_count_high_ff <= nxt_t1[15:8];
         end
      end
   end

   // configuration registers
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         timer_mode_config_ff    <= tmrc_pkg::RST_BYTE;
         clock_divider_select_ff <= 2'h0;
         run_control_bit_ff      <= 2'h0;
      end else if (wr_en) begin
         if (reg_idx == tmrc_pkg::IDX_MODE) begin
            timer_mode_config_ff <= wbyte;
         end
         if (reg_idx == tmrc_pkg::IDX_CKSEL) begin
            clock_divider_select_ff <= {wbyte[tmrc_pkg::CK_FAST1], wbyte[tmrc_pkg::CK_FAST0]};
         end
         if (reg_idx == tmrc_pkg::IDX_CTRL) begin
            run_control_bit_ff <= {wbyte[tmrc_pkg::CTRL_RUN1], wbyte[tmrc_pkg::CTRL_RUN0]};
         end
      end
   end

   // overflow flags: hardware set wins over software write and service clear
   genvar f;
   generate
      for (f = 0; f < 2; f++) begin : g_flag
         localparam int FBIT = (f == 0) ? tmrc_pkg::CTRL_OVF0 : tmrc_pkg::CTRL_OVF1;
         always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
               ovf_flag_ff[f] <= 1'b0;
            end else if (ovf_set[f]) begin
               ovf_flag_ff[f] <= 1'b1;
            end else if (wr_en && reg_idx == tmrc_pkg::IDX_CTRL) begin
               ovf_flag_ff[f] <= wbyte[FBIT];
            end else if (isr_ack[f]) begin
               ovf_flag_ff[f] <= 1'b0;
            end
         end
      end
   endgenerate
   assign overflow_flag = ovf_flag_ff;

   // read data captured in the setup cycle, shown during the access cycle
   always_comb begin
      ctrl_rd = 8'h00;
      ctrl_rd[tmrc_pkg::CTRL_OVF1] = ovf_flag_ff[1];
      ctrl_rd[tmrc_pkg::CTRL_RUN1] = run_control_bit_ff[1];
      ctrl_rd[tmrc_pkg::CTRL_OVF0] = ovf_flag_ff[0];
      ctrl_rd[tmrc_pkg::CTRL_RUN0] = run_control_bit_ff[0];
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         prdata_ff <= 32'h0;
      end else if (psel && !penable) begin
         prdata_ff <= 32'h0;
         if (idx_hit && !pwrite) begin
            unique case (reg_idx)
               tmrc_pkg::IDX_CTRL:  prdata_ff[7:0] <= ctrl_rd;
               tmrc_pkg::IDX_MODE:  prdata_ff[7:0] <= timer_mode_config_ff;
               tmrc_pkg::IDX_T0L:   prdata_ff[7:0] <= timer0_count_low_ff;
               tmrc_pkg::IDX_T1L:   prdata_ff[7:0] <= timer1_count_low_ff;
               tmrc_pkg::IDX_T0H:   prdata_ff[7:0] <= timer0_count_high_ff;
               tmrc_pkg::IDX_T1H:   prdata_ff[7:0] <= timer1_count_high_ff;
               default: begin
                  prdata_ff[tmrc_pkg::CK_FAST1] <= clock_divider_select_ff[1];
                  prdata_ff[tmrc_pkg::CK_FAST0] <= clock_divider_select_ff[0];
               end
            endcase
         end
      end
   end

   a_gate_blocks : assert property (@(posedge clk) disable iff (!resetn)
      cfg0[tmrc_pkg::MODE_GATE] && !evt.gate_hi[0] && !split0 && !wr_en
      |=> $stable({timer0_count_high_ff, timer0_count_low_ff}))
      else $error("gated timer 0 moved while gate pin low");
   a_run_off : assert property (@(posedge clk) disable iff (!resetn)
      !run_control_bit_ff[1] && !wr_en
      |=> $stable({timer1_count_high_ff, timer1_count_low_ff}))
      else $error("timer 1 moved with run bit clear");
   a_edge_count : assert property (@(posedge clk) disable iff (!resetn)
      run_control_bit_ff[0] && cfg0[tmrc_pkg::MODE_CNT_SEL] && !cfg0[tmrc_pkg::MODE_GATE]
      && mode0 == tmrc_pkg::MODE_FULL16 && evt.cnt_fall[0] && !wr_en
      && timer0_count_low_ff != 8'hFF
      |=> timer0_count_low_ff == $past(timer0_count_low_ff) + 8'h01)
      else $error("pin edge did not count");
   a_reload_flag : assert property (@(posedge clk) disable iff (!resetn)
      mode0 == tmrc_pkg::MODE_RELOAD8 && t0_adv && timer0_count_low_ff == 8'hFF && !wr_en
      |=> timer0_count_low_ff == $past(timer0_count_high_ff) && ovf_flag_ff[0])
      else $error("reload or flag missing");
   a_presc_carry : assert property (@(posedge clk) disable iff (!resetn)
      mode0 == tmrc_pkg::MODE_PRESC13 && t0_adv && timer0_count_low_ff[4:0] == 5'h1F
      && !wr_en
      |=> timer0_count_high_ff == $past(timer0_count_high_ff) + 8'h01
          && timer0_count_low_ff[4:0] == 5'h00)
      else $error("prescaler carry wrong");
   a_t1_split_hold : assert property (@(posedge clk) disable iff (!resetn)
      mode1 == tmrc_pkg::MODE_SPLIT && !wr_en
      |=> $stable({timer1_count_high_ff, timer1_count_low_ff}))
      else $error("timer 1 moved in mode 3");
   a_split_high : assert property (@(posedge clk) disable iff (!resetn)
      split0 && !run_control_bit_ff[1] && !wr_en |=> $stable(timer0_count_high_ff))
      else $error("split high byte ran without timer 1 run");
   a_flag_wins : assert property (@(posedge clk) disable iff (!resetn)
      ovf_set[0] |=> ovf_flag_ff[0] ##1 (ovf_flag_ff[0] || $past(isr_ack[0]) || $past(wr_en)))
      else $error("overflow flag lost");
endmodule
`default_nettype wire

// [tmrc_pin_model.sv]
// model of the external count and gate pins feeding the timer core
`timescale 1ns/1ps
`default_nettype none
module tmrc_pin_model (
   // clock
   input  wire logic       clk,
   // pins toward the core
   output logic      [1:0] count_pin,
   output logic      [1:0] gate_input_pin
);
   // count pins idle high so that no falling edge is seen before a pulse
   initial begin
      count_pin      = 2'h3;
      gate_input_pin = 2'h0;
   end

   // low and high each held at least two clocks so the synchroniser sees every edge
   task automatic pulse(input int idx, input int n);
      repeat (n) begin
         @(posedge clk);
         count_pin[idx] <= 1'h0;
         repeat (2) @(posedge clk);
         count_pin[idx] <= 1'h1;
         repeat (2) @(posedge clk);
      end
      // let the edge pass the synchroniser before anyone reads the count
      repeat (4) @(posedge clk);
   endtask

   task automatic set_gate(input int idx, input logic lvl);
      @(posedge clk);
      gate_input_pin[idx] <= lvl;
      repeat (3) @(posedge clk);
   endtask
endmodule
`default_nettype wire

// [tb_dual_timer_counter_core.sv]
// self-checking bench for the dual timer/counter core
`timescale 1ns/1ps
`default_nettype none
module tb_dual_timer_counter_core;
   logic        clk;
   logic        resetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [9:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [1:0]  count_pin;
   logic [1:0]  gate_input_pin;
   logic [1:0]  isr_ack;
   logic [1:0]  overflow_flag;
   int          num_errors;
   int          num_checks;

   tmrc_core #(.ADDR_W(10)) tmrc_core_i (
      .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .count_pin(count_pin), .gate_input_pin(gate_input_pin),
      .isr_ack(isr_ack), .overflow_flag(overflow_flag));

   tmrc_pin_model tmrc_pin_model_i (
      .clk(clk), .count_pin(count_pin), .gate_input_pin(gate_input_pin));

   always #50 clk = ~clk;

   task automatic conclude();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // one apb transfer; waits for pready, never assumes a latency
   task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd,
                      output logic [31:0] rd, output logic err);
      int i;
      @(posedge clk);
      psel    <= 1'h1;
      penable <= 1'h0;
      pwrite  <= w;
      paddr   <= {idx, 2'h0};
      pwdata  <= {24'h000000, wd};
      @(posedge clk);
      penable <= 1'h1;
      for (i = 0; i < 50; i++) begin
         @(posedge clk);
         if (pready === 1'h1) break;
      end
      if (i == 50) begin
         num_errors++;
         conclude();
      end
      rd = prdata;
      err = pslverr;
      psel    <= 1'h0;
      penable <= 1'h0;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [31:0] rd;
      logic        e;
      apb(1'h1, idx, d, rd, e);
   endtask

   task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
      logic [31:0] rd;
      logic        e;
      apb(1'h0, idx, 8'h00, rd, e);
      check(rd, {24'h000000, exp});
      check({31'h0, e}, 32'h0);
   endtask

   task automatic wait_flag(input int t);
      int i;
      for (i = 0; i < 400; i++) begin
         @(negedge clk);
         if (overflow_flag[t] === 1'h1) break;
      end
      if (i == 400) begin
         num_errors++;
         conclude();
      end
   endtask

   task automatic t_regs();
      logic [31:0] rd;
      logic        e;
      for (int k = 8'h88; k <= 8'h8E; k++) begin
         rdchk(8'(k), 8'h00);
      end
      wr(tmrc_pkg::IDX_T0L, 8'h5A);
      wr(tmrc_pkg::IDX_T0H, 8'hA5);
      wr(tmrc_pkg::IDX_T1L, 8'h3C);
      wr(tmrc_pkg::IDX_T1H, 8'hC3);
      rdchk(tmrc_pkg::IDX_T0L, 8'h5A);
      rdchk(tmrc_pkg::IDX_T0H, 8'hA5);
      rdchk(tmrc_pkg::IDX_T1L, 8'h3C);
      rdchk(tmrc_pkg::IDX_T1H, 8'hC3);
      wr(tmrc_pkg::IDX_CTRL, 8'hAF);
      rdchk(tmrc_pkg::IDX_CTRL, 8'hA0);
      check({30'h0, overflow_flag}, 32'h3);
      wr(tmrc_pkg::IDX_CTRL, 8'h00);
      rdchk(tmrc_pkg::IDX_CTRL, 8'h00);
      apb(1'h0, 8'h87, 8'h00, rd, e);
      check({31'h0, e}, 32'h1);
      check(rd, 32'h0);
      apb(1'h1, 8'h8F, 8'hFF, rd, e);
      check({31'h0, e}, 32'h1);
   endtask

   // reload value FE makes two ticks per overflow, so the period exposes the divider
   task automatic t_reload();
      int c;
      for (int t = 0; t < 2; t++) begin
         for (int f = 0; f < 2; f++) begin
            wr(tmrc_pkg::IDX_CTRL, 8'h00);
            wr(tmrc_pkg::IDX_MODE, (t == 1) ? 8'h20 : 8'h02);
            wr(tmrc_pkg::IDX_CKSEL, 8'(f) << (tmrc_pkg::CK_FAST0 + t));
            wr((t == 1) ? tmrc_pkg::IDX_T1H : tmrc_pkg::IDX_T0H, 8'hFE);
            wr((t == 1) ? tmrc_pkg::IDX_T1L : tmrc_pkg::IDX_T0L, 8'hFF);
            wr(tmrc_pkg::IDX_CTRL, 8'h10 << (2 * t));
            wait_flag(t);
            @(posedge clk);
            isr_ack[t] <= 1'h1;
            @(negedge clk);
            c = 1;
            @(posedge clk);
            isr_ack[t] <= 1'h0;
            do begin
               @(negedge clk);
               c++;
            end while (overflow_flag[t] !== 1'h1 && c < 100);
            check(32'(c), 32'(2 * ((f == 1) ? tmrc_pkg::DIV_FAST : tmrc_pkg::DIV_SLOW)));
            if (c >= 100) conclude();
         end
      end
      wr(tmrc_pkg::IDX_CTRL, 8'h00);
   endtask

   task automatic t_count();
      wr(tmrc_pkg::IDX_MODE, 8'h05);
      wr(tmrc_pkg::IDX_T0L, 8'h00);
      wr(tmrc_pkg::IDX_T0H, 8'h00);
      wr(tmrc_pkg::IDX_CTRL, 8'h10);
      tmrc_pin_model_i.pulse(0, 3);
      rdchk(tmrc_pkg::IDX_T0L, 8'h03);
      wr(tmrc_pkg::IDX_MODE, 8'h0D);
      tmrc_pin_model_i.pulse(0, 2);
      rdchk(tmrc_pkg::IDX_T0L, 8'h03);
      tmrc_pin_model_i.set_gate(0, 1'h1);
      tmrc_pin_model_i.pulse(0, 2);
      rdchk(tmrc_pkg::IDX_T0L, 8'h05);
      wr(tmrc_pkg::IDX_CTRL, 8'h00);
      tmrc_pin_model_i.pulse(0, 1);
      rdchk(tmrc_pkg::IDX_T0L, 8'h05);
      tmrc_pin_model_i.set_gate(0, 1'h0);
   endtask

   task automatic t_modes();
      wr(tmrc_pkg::IDX_MODE, 8'h44);
      wr(tmrc_pkg::IDX_T1H, 8'hFF);
      wr(tmrc_pkg::IDX_T1L, 8'hFE);
      wr(tmrc_pkg::IDX_T0H, 8'hFF);
      wr(tmrc_pkg::IDX_T0L, 8'hFE);
      wr(tmrc_pkg::IDX_CTRL, 8'h50);
      tmrc_pin_model_i.pulse(1, 3);
      tmrc_pin_model_i.pulse(0, 3);
      rdchk(tmrc_pkg::IDX_T1L, 8'hE1);
      rdchk(tmrc_pkg::IDX_T1H, 8'h00);
      rdchk(tmrc_pkg::IDX_T0L, 8'hE1);
      rdchk(tmrc_pkg::IDX_T0H, 8'h00);
      check({30'h0, overflow_flag}, 32'h3);
      wr(tmrc_pkg::IDX_CTRL, 8'h00);
      wr(tmrc_pkg::IDX_MODE, 8'h50);
      wr(tmrc_pkg::IDX_T1H, 8'h00);
      wr(tmrc_pkg::IDX_T1L, 8'hFE);
      wr(tmrc_pkg::IDX_CTRL, 8'h40);
      tmrc_pin_model_i.pulse(1, 3);
      rdchk(tmrc_pkg::IDX_T1L, 8'h01);
      rdchk(tmrc_pkg::IDX_T1H, 8'h01);
   endtask

   task automatic t_split();
      wr(tmrc_pkg::IDX_CTRL, 8'h00);
      wr(tmrc_pkg::IDX_CKSEL, 8'h08);
      wr(tmrc_pkg::IDX_MODE, 8'h77);
      wr(tmrc_pkg::IDX_T0L, 8'h00);
      wr(tmrc_pkg::IDX_T0H, 8'hF0);
      wr(tmrc_pkg::IDX_T1L, 8'h55);
      wr(tmrc_pkg::IDX_T1H, 8'h66);
      wr(tmrc_pkg::IDX_CTRL, 8'h50);
      tmrc_pin_model_i.pulse(0, 2);
      tmrc_pin_model_i.pulse(1, 2);
      wait_flag(1);
      rdchk(tmrc_pkg::IDX_T0L, 8'h02);
      rdchk(tmrc_pkg::IDX_T1L, 8'h55);
      rdchk(tmrc_pkg::IDX_T1H, 8'h66);
      check({31'h0, overflow_flag[0]}, 32'h0);
   endtask

   initial begin
      clk            = 1'h0;
      resetn         = 1'h0;
      psel           = 1'h0;
      penable        = 1'h0;
      pwrite         = 1'h0;
      paddr          = 10'h000;
      pwdata         = 32'h0;
      isr_ack        = 2'h0;
      num_errors     = 0;
      num_checks     = 0;
      repeat (20) @(posedge clk);
      resetn <= 1'h1;
      t_regs();
      t_reload();
      t_count();
      t_modes();
      t_split();
      conclude();
   end

   // a hang anywhere ends the run as a failure
   initial begin
      repeat (90000) @(posedge clk);
      num_errors++;
      conclude();
   end
endmodule
`default_nettype wire
